// >>> verilog/fbmc_pkg.sv
package fbmc_pkg;

    // Bus geometry
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    localparam int SECT_LO = 16;
    localparam int SECT_W = 3;

    // Timing at 125 MHz
    localparam int CLK_PERIOD_NS = 8;
    localparam int ADDR_SETTLE_TIME_NS = 120;
    localparam int ADDR_SETTLE_CYC =
        (ADDR_SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_TIME_NS = 40;
    localparam int SETUP_CYC = (SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_TIME_NS = 48;
    localparam int STROBE_CYC = (STROBE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GLITCH_TIME_NS = 5;
    localparam int CNT_W = 8;

    // Command words
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 19'h0_0555;
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 19'h0_02AA;
    localparam logic [DATA_W-1:0] UNLOCK_DATA1 = 8'hAA;
    localparam logic [DATA_W-1:0] UNLOCK_DATA2 = 8'h55;
    localparam logic [DATA_W-1:0] CMD_PROGRAM = 8'hA0;
    localparam logic [DATA_W-1:0] CMD_ERASE_SETUP = 8'h80;
    localparam logic [DATA_W-1:0] CMD_SECTOR_ERASE = 8'h30;
    localparam logic [DATA_W-1:0] CMD_CHIP_ERASE = 8'h10;
    localparam logic [DATA_W-1:0] CMD_ID_ENTRY = 8'h90;
    localparam logic [DATA_W-1:0] CMD_RESET = 8'hF0;
    localparam logic [ADDR_W-1:0] ID_MAKER_OFS = 19'h0_0000;
    localparam logic [ADDR_W-1:0] ID_PART_OFS = 19'h0_0001;
    localparam logic [ADDR_W-1:0] ID_PROT_OFS = 19'h0_0002;
    localparam logic [DATA_W-1:0] PROT_SET = 8'h01;
    localparam logic [DATA_W-1:0] PROT_CLEAR = 8'h00;
    localparam int STATUS_DONE_BIT = 7;
    localparam int TIMEOUT_BIT = 5;

    // Host request kinds
    typedef enum logic [2:0] {
        OP_READ = 3'b000,
        OP_PROGRAM = 3'b001,
        OP_SECTOR_ERASE = 3'b010,
        OP_CHIP_ERASE = 3'b011,
        OP_ID_READ = 3'b100,
        OP_HV_ID_READ = 3'b101,
        OP_RESET = 3'b110
    } fbmc_op_e;

    typedef struct packed {
        fbmc_op_e op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } fbmc_req_s;

    // Flash side pins, outputs of the host
    typedef struct packed {
        logic chip_select_n;
        logic output_gate_n;
        logic write_strobe_n;
        logic high_voltage_id_pin;
        logic [ADDR_W-1:0] address_lines;
        logic [DATA_W-1:0] data_out;
        logic data_oe;
    } fbmc_pins_s;

    // Sequencer script entry
    typedef struct packed {
        logic is_write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } fbmc_step_s;

endpackage

// >>> verilog/fbmc_script.sv
`timescale 1ns/100ps
`default_nettype none
module fbmc_script
    import fbmc_pkg::*;
(
    // Clock
    input  wire logic             clk,
    input  wire logic             reset,
    // Lookup
    input  wire fbmc_req_s        req,
    input  wire logic [2:0]       idx,
    output fbmc_step_s            step,
    output logic                  last
);
    fbmc_step_s next_step;
    logic       next_last;
    logic [ADDR_W-1:0] sect_base;

    assign sect_base = {req.addr[ADDR_W-1:SECT_LO], {SECT_LO{1'b0}}};

    always_comb begin
        next_step = '{is_write: 1'b1, addr: UNLOCK_ADDR1, data: UNLOCK_DATA1};
        next_last = 1'b0;
        case (idx)
            3'd0: begin
                if (req.op == OP_RESET) begin
                    next_step.data = CMD_RESET;
                    next_last = 1'b1;
                end else if (req.op == OP_READ || req.op == OP_HV_ID_READ) begin
                    next_step = '{is_write: 1'b0, addr: req.addr, data: 8'h00};
                    next_last = 1'b1;
                end
            end
            3'd1, 3'd4: begin
                next_step.addr = UNLOCK_ADDR2;
                next_step.data = UNLOCK_DATA2;
            end
            3'd2: begin
                if (req.op == OP_PROGRAM) begin
                    next_step.data = CMD_PROGRAM;
                end else if (req.op == OP_ID_READ) begin
                    next_step.data = CMD_ID_ENTRY;
                end else begin
                    next_step.data = CMD_ERASE_SETUP;
                end
            end
            3'd3: begin
                if (req.op == OP_PROGRAM) begin
                    next_step = '{is_write: 1'b1, addr: req.addr, data: req.data};
                    next_last = 1'b1;
                end else if (req.op == OP_ID_READ) begin
                    next_step = '{is_write: 1'b0, addr: sect_base | req.addr[1:0], data: 8'h00};
                end
            end
            3'd5: begin
                if (req.op == OP_SECTOR_ERASE) begin
                    next_step = '{is_write: 1'b1, addr: sect_base, data: CMD_SECTOR_ERASE};
                end else begin
                    next_step.data = CMD_CHIP_ERASE;
                end
                next_last = 1'b1;
            end
            default: begin
                next_step.data = CMD_RESET;
                next_last = 1'b1;
            end
        endcase
        if (req.op == OP_ID_READ && idx == 3'd4) begin
            next_step.data = CMD_RESET;
            next_step.addr = UNLOCK_ADDR1;
            next_last = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            step <= '0;
            last <= 1'b0;
        end else begin
            step <= next_step;
            last <= next_last;
        end
    end
endmodule
`default_nettype wire

// >>> verilog/fbmc_host.sv
`timescale 1ns/100ps
`default_nettype none
module fbmc_host
    import fbmc_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    // Request
    input  wire logic              req_valid,
    input  wire fbmc_req_s         req,
    output logic                   req_ready,
    // Answer
    output logic                   rsp_valid,
    output logic [DATA_W-1:0]      rsp_data,
    output logic                   rsp_busy,
    output logic                   rsp_timeout,
    // Flash pins
    output fbmc_pins_s             pins,
    input  wire logic [DATA_W-1:0] data_lines_in
);
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_SETUP  = 3'b001,
        ST_STROBE = 3'b010,
        ST_HOLD   = 3'b011,
        ST_POLL   = 3'b100,
        ST_DONE   = 3'b101
    } fbmc_state_e;

    fbmc_state_e       state;
    fbmc_req_s         cur;
    logic [2:0]        idx;
    logic [CNT_W-1:0]  cnt;
    logic [DATA_W-1:0] din_meta;
    logic [DATA_W-1:0] din_sync;
    fbmc_step_s        step;
    logic              step_last;
    logic              polling;
    logic              need_reset;

    fbmc_script u_script (
        .clk   (clk),
        .reset (reset),
        .req   (cur),
        .idx   (idx),
        .step  (step),
        .last  (step_last)
    );

    // Derived conditions
    wire cnt_done   = (cnt == '0);
    // Status judged from the byte taken while selected, not the released bus
    wire poll_done  = rsp_data[STATUS_DONE_BIT] == cur.data[STATUS_DONE_BIT];
    wire poll_fail  = rsp_data[TIMEOUT_BIT] && !poll_done;
    wire is_erase   = cur.op == OP_SECTOR_ERASE || cur.op == OP_CHIP_ERASE;
    wire is_hv      = cur.op == OP_HV_ID_READ;
    wire [CNT_W-1:0] setup_cnt  = CNT_W'(SETUP_CYC);
    wire [CNT_W-1:0] strobe_cnt = CNT_W'(STROBE_CYC);
    wire [CNT_W-1:0] read_cnt   = CNT_W'(ADDR_SETTLE_CYC + 2);

    // Data pins cross from the device, two stages
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            din_meta <= '0;
            din_sync <= '0;
        end else begin
            din_meta <= data_lines_in;
            din_sync <= din_meta;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state      <= ST_IDLE;
            cur        <= '0;
            idx        <= '0;
            cnt        <= '0;
            polling    <= 1'b0;
            need_reset <= 1'b1;
            req_ready  <= 1'b0;
            rsp_valid  <= 1'b0;
            rsp_data   <= '0;
            rsp_busy   <= 1'b0;
            rsp_timeout <= 1'b0;
            pins       <= '{chip_select_n: 1'b1, output_gate_n: 1'b1,
                            write_strobe_n: 1'b1, default: '0};
        end else begin
            rsp_valid <= 1'b0;
            case (state)
                ST_IDLE: begin
                    pins.chip_select_n  <= 1'b1;
                    pins.output_gate_n  <= 1'b1;
                    pins.write_strobe_n <= 1'b1;
                    pins.data_oe        <= 1'b0;
                    pins.high_voltage_id_pin <= 1'b0;
                    req_ready <= 1'b1;
                    rsp_timeout <= 1'b0;
                    if (need_reset) begin
                        cur <= '{op: OP_RESET, default: '0};
                        need_reset <= 1'b0;
                        req_ready <= 1'b0;
                        idx <= '0;
                        cnt <= setup_cnt;
                        state <= ST_SETUP;
                    end else if (req_valid && req_ready) begin
                        cur <= req;
                        req_ready <= 1'b0;
                        rsp_busy <= 1'b1;
                        idx <= '0;
                        cnt <= setup_cnt;
                        state <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    // Script lookup is registered, one wait cycle folds into setup
                    pins.address_lines <= step.addr;
                    pins.data_out      <= step.data;
                    pins.high_voltage_id_pin <= is_hv;
                    if (is_hv) begin
                        pins.address_lines[6] <= 1'b0;
                    end
                    pins.write_strobe_n <= 1'b1;
                    // Gate stays high until select is low
                    pins.output_gate_n  <= 1'b1;
                    pins.data_oe        <= step.is_write;
                    if (cnt_done) begin
                        pins.chip_select_n <= 1'b0;
                        if (step.is_write) begin
                            pins.write_strobe_n <= 1'b0;
                            cnt <= strobe_cnt;
                        end else begin
                            pins.output_gate_n <= 1'b0;
                            cnt <= read_cnt;
                        end
                        state <= ST_STROBE;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                ST_STROBE: begin
                    if (cnt_done) begin
                        pins.write_strobe_n <= 1'b1;
                        pins.output_gate_n  <= 1'b1;
                        pins.chip_select_n  <= 1'b1;
                        if (!step.is_write) begin
                            rsp_data <= din_sync;
                        end
                        cnt <= setup_cnt;
                        state <= ST_HOLD;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                ST_HOLD: begin
                    pins.data_oe <= 1'b0;
                    if (cnt_done) begin
                        cnt <= setup_cnt;
                        if (polling && poll_done) begin
                            polling <= 1'b0;
                            state <= ST_DONE;
                        end else if (polling && poll_fail) begin
                            polling <= 1'b0;
                            rsp_timeout <= 1'b1;
                            need_reset <= 1'b1;
                            state <= ST_DONE;
                        end else if (polling) begin
                            state <= ST_SETUP;
                        end else if (step_last) begin
                            if (cur.op == OP_PROGRAM || is_erase) begin
                                polling <= 1'b1;
                                state <= ST_POLL;
                            end else begin
                                state <= ST_DONE;
                            end
                        end else begin
                            idx <= idx + 3'd1;
                            state <= ST_SETUP;
                        end
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                ST_POLL: begin
                    // Status read at the operation address
                    if (is_erase) begin
                        cur.data <= 8'hFF;
                    end
                    idx <= '0;
                    cur.op <= OP_READ;
                    state <= ST_SETUP;
                end
                ST_DONE: begin
                    rsp_valid <= cur.op != OP_RESET || rsp_timeout;
                    rsp_busy  <= 1'b0;
                    if (cur.op == OP_ID_READ) begin
                        rsp_data <= rsp_data;
                    end
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> bench/fbmc_host_sva.sv
`timescale 1ns/100ps
`default_nettype none
module fbmc_host_sva
    import fbmc_pkg::*;
(
    // Clock
    input wire logic              clk,
    input wire logic              reset,
    // Request and answer
    input wire logic              req_valid,
    input wire fbmc_req_s         req,
    input wire logic              req_ready,
    input wire logic              rsp_valid,
    input wire logic [DATA_W-1:0] rsp_data,
    input wire logic              rsp_busy,
    input wire logic              rsp_timeout,
    // Flash pins
    input wire fbmc_pins_s        pins,
    input wire logic [DATA_W-1:0] data_lines_in
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire logic  cs_n = pins.chip_select_n;
    wire logic  oe_n = pins.output_gate_n;
    wire logic  we_n = pins.write_strobe_n;
    logic [7:0] low_cnt;
    // Cycles with output gate low
    always_ff @(posedge clk or posedge reset)
        if (reset) low_cnt <= 8'h00;
        else if (oe_n) low_cnt <= 8'h00;
        else if (low_cnt != 8'hFF) low_cnt <= low_cnt + 8'h01;
    property p_wr; !we_n |-> !cs_n && oe_n && pins.data_oe; endproperty
    a_wr: assert property (p_wr) else $error("bad write levels");
    property p_rd; !oe_n |-> !cs_n && we_n && !pins.data_oe; endproperty
    a_rd: assert property (p_rd) else $error("bad read levels");
    property p_hold;
        !we_n && !$past(we_n) |-> $stable(pins.address_lines) && $stable(pins.data_out);
    endproperty
    a_hold: assert property (p_hold) else $error("write moved");
    property p_rise; $rose(we_n) |-> $stable(pins.data_out) && pins.data_oe; endproperty
    a_rise: assert property (p_rise) else $error("data not held");
    property p_strobe; $fell(we_n) |-> !we_n [*6]; endproperty
    a_strobe: assert property (p_strobe) else $error("short strobe");
    property p_acc; $rose(oe_n) |-> low_cnt >= 8'(ADDR_SETTLE_CYC); endproperty
    a_acc: assert property (p_acc) else $error("short access");
    property p_hv; pins.high_voltage_id_pin && !oe_n |-> !pins.address_lines[6]; endproperty
    a_hv: assert property (p_hv) else $error("id bit6 high");
    property p_pulse; rsp_valid |=> !rsp_valid; endproperty
    a_pulse: assert property (p_pulse) else $error("long answer");
endmodule
bind fbmc_host fbmc_host_sva fbmc_host_sva_i (
    .clk(clk), .reset(reset), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_busy(rsp_busy),
    .rsp_timeout(rsp_timeout), .pins(pins), .data_lines_in(data_lines_in)
);
`default_nettype wire

// >>> bench/fbmc_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
module fbmc_flash_model
    import fbmc_pkg::*;
#(
    parameter int         OP_NS = 2000,
    parameter logic [7:0] MAKER = 8'h3C, // Arbitrary value
    parameter logic [7:0] PART  = 8'hC3  // Arbitrary value
)
(
    // Bus from host
    input  wire fbmc_pins_s   pins,
    // Data toward host
    output logic [DATA_W-1:0] dq
);
    logic [7:0]  mem [0:524287];
    logic [7:0]  prot = 8'h00;
    logic [2:0]  st = 3'd0;
    logic [7:0]  pd = 8'hFF;
    logic [7:0]  last = 8'h00;
    logic        busy = 1'b0;
    logic        tmo = 1'b0;
    logic        lockout = 1'b0;
    logic [18:0] al;
    realtime     t_on = 0.0;
    wire logic [18:0] a = pins.address_lines;
    wire logic wr = !pins.chip_select_n && !pins.write_strobe_n && pins.output_gate_n;
    wire logic rd = !pins.chip_select_n && !pins.output_gate_n && pins.write_strobe_n;
    wire logic [7:0] idv = a[1:0] == 2'd0 ? MAKER : a[1:0] == 2'd1 ? PART :
        {7'h00, prot[a[18:16]]};
    wire logic idm = st == 3'd7 || (pins.high_voltage_id_pin && !a[6]);
    wire logic [7:0] rv = busy || tmo ? {~pd[7], 1'b0, tmo, 5'h00} : idm ? idv : mem[a];
    initial foreach (mem[i]) mem[i] = 8'hFF;
    // Released bus shows the inverse of the last byte
    always @* begin
        if (rd) last = rv;
        dq = rd ? rv : ~last;
    end
    always @(posedge wr) begin
        al = a;
        t_on = $realtime;
    end
    always @(negedge wr) begin
        if ($realtime - t_on >= 5.0) cmd(al, pins.data_out);
    end
    task automatic go(input logic [7:0] d);
        pd = d;
        busy = 1'b1;
        busy <= #(OP_NS) 1'b0;
    endtask
    task automatic cmd(input logic [18:0] ca, input logic [7:0] cd);
        if (lockout) begin
            st = 3'd0;
            tmo = 1'b0;
            return;
        end
        if (busy) return;
        if (cd == CMD_RESET && st != 3'd3) begin
            st = 3'd0;
            tmo = 1'b0;
        end else if (!tmo) begin
            case (st)
                3'd0, 3'd4: st = ca == UNLOCK_ADDR1 && cd == UNLOCK_DATA1 ? st + 3'd1 : 3'd0;
                3'd1, 3'd5: st = ca == UNLOCK_ADDR2 && cd == UNLOCK_DATA2 ? st + 3'd1 : 3'd0;
                3'd2: st = cd == CMD_PROGRAM ? 3'd3 : cd == CMD_ERASE_SETUP ? 3'd4 :
                    cd == CMD_ID_ENTRY ? 3'd7 : 3'd0;
                3'd3: begin
                    st = 3'd0;
                    if (!prot[ca[18:16]]) begin
                        // Failed program stops at once with the flag up
                        tmo = |(cd & ~mem[ca]);
                        pd = cd;
                        if (!tmo) begin
                            go(cd);
                            mem[ca] = cd;
                        end
                    end
                end
                3'd6: begin
                    st = 3'd0;
                    if (cd == CMD_SECTOR_ERASE || cd == CMD_CHIP_ERASE) begin
                        go(8'hFF);
                        for (int s = 0; s < 8; s++)
                            if (!prot[s] && (cd == CMD_CHIP_ERASE || s == ca[18:16]))
                                for (int k = 0; k < 65536; k++) mem[s * 65536 + k] = 8'hFF;
                    end
                end
                default: st = 3'd0;
            endcase
        end
    endtask
endmodule
`default_nettype wire

// >>> bench/flash_bus_mode_control_test.sv
`timescale 1ns/100ps
`default_nettype none
module flash_bus_mode_control_test
    import fbmc_pkg::*;
;
    localparam int         OP_NS = 2000;
    localparam logic [7:0] MAKER = 8'h3C; // Arbitrary value
    localparam logic [7:0] PART  = 8'hC3; // Arbitrary value
    logic                   clk = 1'b0;
    logic                   reset = 1'b1;
    logic                   req_valid = 1'b0;
    fbmc_req_s              req = '0;
    logic                   req_ready, rsp_valid, rsp_busy, rsp_timeout, tmo_seen;
    logic [DATA_W-1:0]      rsp_data, dq, rd, d;
    logic [ADDR_W-1:0]      a;
    logic [7:0]             prot_exp = 8'h00;
    logic [7:0]             exp_mem [logic [ADDR_W-1:0]];
    fbmc_pins_s             pins;
    int                     num_errors = 0;
    int                     n_checks = 0;
    int                     cyc = 0;
    int                     seed = 32'h0000_819d;
    wire logic [DATA_W-1:0] data_lines_in = pins.data_oe ? pins.data_out : dq;
    fbmc_host fbmc_host_i (
        .clk(clk), .reset(reset), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_busy(rsp_busy),
        .rsp_timeout(rsp_timeout), .pins(pins), .data_lines_in(data_lines_in)
    );
    fbmc_flash_model #(.OP_NS(OP_NS), .MAKER(MAKER), .PART(PART)) fbmc_flash_model_i (
        .pins(pins), .dq(dq)
    );
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            num_errors = num_errors + 1;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] exp_rd(input logic [ADDR_W-1:0] ea);
        return exp_mem.exists(ea) ? exp_mem[ea] : 8'hFF;
    endfunction
    function automatic logic [7:0] id_exp(input logic [ADDR_W-1:0] ea);
        return ea[1:0] == 2'd0 ? MAKER : ea[1:0] == 2'd1 ? PART : {7'h00, prot_exp[ea[18:16]]};
    endfunction
    task automatic do_op(input fbmc_op_e op, input logic [ADDR_W-1:0] ea, input logic [7:0] ed);
        @(negedge clk);
        while (req_ready !== 1'b1) @(negedge clk);
        req_valid = 1'b1;
        req = {op, ea, ed};
        @(negedge clk);
        req_valid = 1'b0;
        check({7'h00, rsp_busy}, 8'h01);
        if (op == OP_RESET) repeat (2) @(negedge clk);
        else for (int n = 0; n < 20000 && rsp_valid !== 1'b1; n++) @(negedge clk);
        if (op != OP_RESET) check({7'h00, rsp_valid}, 8'h01);
        rd = rsp_data;
        tmo_seen = rsp_timeout;
    endtask
    task automatic prog_chk(input logic [ADDR_W-1:0] ea, input logic [7:0] ed);
        logic bad;
        bad = !prot_exp[ea[18:16]] && |(ed & ~exp_rd(ea));
        do_op(OP_PROGRAM, ea, ed);
        check({7'h00, tmo_seen}, {7'h00, bad});
        if (!prot_exp[ea[18:16]] && !bad) exp_mem[ea] = ed;
        do_op(OP_READ, ea, 8'h00);
        check(rd, exp_rd(ea));
    endtask
    task automatic erase_chk(input fbmc_op_e op, input logic [ADDR_W-1:0] ea);
        do_op(op, ea, 8'h00);
        foreach (exp_mem[k])
            if (!prot_exp[k[18:16]] && (op == OP_CHIP_ERASE || k[18:16] == ea[18:16]))
                exp_mem[k] = 8'hFF;
        foreach (exp_mem[k]) begin
            do_op(OP_READ, k, 8'h00);
            check(rd, exp_mem[k]);
        end
    endtask
    initial begin
        repeat (5) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        for (int i = 0; i < 8; i++) begin
            {a, d} = 27'($random(seed));
            if (i == 0) a = 19'h0_0000;
            if (i == 1) a = 19'h7_FFFF;
            do_op(OP_READ, a, 8'h00);
            check(rd, exp_rd(a));
            prog_chk(a, d);
        end
        prog_chk(19'h1_FFFF, 8'h5A);
        prog_chk(19'h2_0000, 8'hA5);
        prog_chk(19'h2_0000, 8'h5A);
        prog_chk(19'h3_0010, 8'hC7);
        erase_chk(OP_SECTOR_ERASE, 19'h1_0000);
        $display("test program and erase done");
        fbmc_flash_model_i.prot[3] = 1'b1;
        prot_exp[3] = 1'b1;
        for (int k = 0; k < 12; k++) begin
            a = {3'(k), 14'h0000, 2'(k % 3)};
            a[6] = k[0];
            do_op(OP_ID_READ, a, 8'h00);
            check(rd, id_exp(a));
            do_op(OP_HV_ID_READ, a, 8'h00);
            check(rd, id_exp(a));
        end
        $display("test identification done");
        prog_chk(19'h3_0020, 8'h80 | d);
        erase_chk(OP_SECTOR_ERASE, 19'h3_0000);
        erase_chk(OP_CHIP_ERASE, 19'h0_0000);
        fbmc_flash_model_i.lockout = 1'b1;
        do_op(OP_PROGRAM, 19'h4_0040, 8'h81);
        fbmc_flash_model_i.lockout = 1'b0;
        do_op(OP_READ, 19'h4_0040, 8'h00);
        check(rd, exp_rd(19'h4_0040));
        fbmc_flash_model_i.prot[3] = 1'b0;
        prot_exp[3] = 1'b0;
        prog_chk(19'h3_0020, 8'h00);
        do_op(OP_RESET, 19'h5_5555, 8'h00);
        do_op(OP_READ, 19'h3_0010, 8'h00);
        check(rd, 8'hC7);
        $display("test protection done");
        stop_test();
    end
endmodule
`default_nettype wire
